/* logic/led_output_pwm_stage.v */
`timescale 1ns/1ns
`default_nettype none
`include "led_stage_consts.vh"
module led_output_pwm_stage
#(
  parameter CHANNELS    = 8,
  parameter IND_CYCLES  = `IND_TICK_CYCLES,
  parameter GRP_CYCLES  = `GRP_TICK_CYCLES,
  parameter BLINK_CYCLES = `BLINK_TICK_CYCLES
)
(
  input  wire                ref_clk,
  input  wire                rst_n,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output wire                pready,
  output wire                pslverr,
  input  wire                output_disable,
  output reg  [CHANNELS-1:0] led_pin_out,
  output reg  [CHANNELS-1:0] led_pin_oe
);
  // ==========================================================
  // registers
  reg  [7:0]            mode1;
  reg  [7:0]            second_mode_register;
  reg  [7:0]            group_duty_value;
  reg  [7:0]            group_period;
  reg  [2*CHANNELS-1:0] channel_output_select;
  reg  [7:0]            channel_duty_value [0:CHANNELS-1];
  reg                   oe_meta;
  reg                   oe_sync;
  integer               i;
  wire sleep                    = mode1[`MODE1_SLEEP_BIT];
  wire group_blink_select       = second_mode_register[`SECOND_MODE_REGISTER_BLINK_BIT];
  wire output_polarity_invert   = second_mode_register[`SECOND_MODE_REGISTER_INVERT_BIT];
  wire totem_pole_drive_select  = second_mode_register[`SECOND_MODE_REGISTER_TOTEM_BIT];
  wire [1:0] disabled_output_state = second_mode_register[`SECOND_MODE_REGISTER_DISABLED_OUTPUT_STATE_LSB+1:`SECOND_MODE_REGISTER_DISABLED_OUTPUT_STATE_LSB];
  wire access = psel && penable;
  wire duty_hit = (paddr >= `REG_DUTY_BASE) && (paddr < `REG_DUTY_BASE + 4*CHANNELS)
                  && (paddr[1:0] == 2'b00);
  wire [7:0] duty_idx = (paddr - `REG_DUTY_BASE) >> 2;
  wire known = (paddr == `REG_MODE1) || (paddr == `REG_SECOND_MODE_REGISTER)
               || (paddr == `REG_GROUP_DUTY) || (paddr == `REG_GROUP_PERIOD)
               || (paddr == `REG_SELECT) || duty_hit;
  assign pready  = 1'b1;
  assign pslverr = access && !known;
  // ==========================================================
  // apb writes, enable pin synchroniser
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode1                 <= `MODE1_RESET;
      second_mode_register  <= `SECOND_MODE_REGISTER_RESET;
      group_duty_value      <= `GROUP_DUTY_RESET;
      group_period          <= 8'h00;
      channel_output_select <= {2*CHANNELS{1'b0}};
      for (i = 0; i < CHANNELS; i = i + 1)
        channel_duty_value[i] <= 8'h00;
      // reset to enabled: a disabled reset value would park the pins low
      // for two cycles after reset instead of leaving them high
      oe_meta <= 1'b0;
      oe_sync <= 1'b0;
    end
    else
    begin
      oe_meta <= output_disable;
      oe_sync <= oe_meta;
      if (access && pwrite)
      begin
        if (paddr == `REG_MODE1)
          mode1 <= pwdata[7:0];
        if (paddr == `REG_SECOND_MODE_REGISTER)
          second_mode_register <= pwdata[7:0];
        if (paddr == `REG_GROUP_DUTY)
          group_duty_value <= pwdata[7:0];
        if (paddr == `REG_GROUP_PERIOD)
          group_period <= pwdata[7:0];
        if (paddr == `REG_SELECT)
          channel_output_select <= pwdata[2*CHANNELS-1:0];
        if (duty_hit)
          channel_duty_value[duty_idx[2:0]] <= pwdata[7:0];
      end
    end
  end
  // ==========================================================
  // read mux, state bits show live pin levels
  // captured in the setup cycle so read data comes from a flop and stands all access
  reg  [31:0] next_prdata;
  always @*
  begin
    next_prdata = 32'h00000000;
    if (paddr == `REG_MODE1)
      next_prdata = {24'h000000, mode1};
    else if (paddr == `REG_SECOND_MODE_REGISTER)
      next_prdata = {16'h0000, led_pin_out[7:0], second_mode_register};
    else if (paddr == `REG_GROUP_DUTY)
      next_prdata = {24'h000000, group_duty_value};
    else if (paddr == `REG_GROUP_PERIOD)
      next_prdata = {24'h000000, group_period};
    else if (paddr == `REG_SELECT)
      next_prdata[2*CHANNELS-1:0] = channel_output_select;
    else if (duty_hit)
      next_prdata = {24'h000000, channel_duty_value[duty_idx[2:0]]};
  end
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= next_prdata;
  end
  // ==========================================================
  // pwm timebases; sleep stops them so nothing moves
  wire [7:0] ind_phase;
  wire [7:0] dim_phase;
  wire [7:0] blink_phase;
  wire       blink_wrap;
  pwm_counter #(.PRESCALE(IND_CYCLES)) u_ind
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .run      (!sleep),
    .steps_m1 (8'hff),
    .phase    (ind_phase),
    .wrap     ()
  );
  pwm_counter #(.PRESCALE(GRP_CYCLES)) u_dim
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .run      (!sleep),
    .steps_m1 (8'hff),
    .phase    (dim_phase),
    .wrap     ()
  );
  // blink: base tick gives 24 hz; each step repeated period+1 times
  reg  [7:0] stretch;
  wire [7:0] blink_raw;
  wire       blink_step;
  pwm_counter #(.PRESCALE(BLINK_CYCLES)) u_blink
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .run      (!sleep && (stretch == group_period)),
    .steps_m1 (group_period),
    .phase    (blink_raw),
    .wrap     (blink_wrap)
  );
  assign blink_step = 1'b1;
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      stretch <= 8'h00;
    else if (!sleep)
      stretch <= (stretch == group_period) ? 8'h00 : stretch + 8'h01;
  end
  assign blink_phase = blink_raw;
  // ==========================================================
  // group signal and per-pin drive
  function pwm_high;
    input [7:0] phase;
    input [7:0] duty;
    begin
      pwm_high = (phase < duty);
    end
  endfunction
  wire group_active = group_blink_select
                      ? pwm_high(blink_phase, group_duty_value)
                      : pwm_high(dim_phase, group_duty_value);
  reg  [CHANNELS-1:0] next_pin_out;
  reg  [CHANNELS-1:0] next_pin_oe;
  reg  [1:0]          sel;
  reg                 active;
  reg                 low;
  integer             c;
  always @*
  begin
    next_pin_out = {CHANNELS{1'b1}};
    next_pin_oe  = {CHANNELS{1'b1}};
    sel          = 2'b00;
    active       = 1'b0;
    low          = 1'b0;
    for (c = 0; c < CHANNELS; c = c + 1)
    begin
      sel = channel_output_select[2*c +: 2];
      case (sel)
        2'b00: active = 1'b0;
        2'b01: active = 1'b1;
        2'b10: active = pwm_high(ind_phase, channel_duty_value[c]);
        2'b11: active = pwm_high(ind_phase, channel_duty_value[c]) && group_active;
        default: active = 1'b0;
      endcase
      low = active ^ output_polarity_invert;
      if (oe_sync)
      begin
        case (disabled_output_state)
          2'b00:
          begin
            next_pin_out[c] = 1'b0;
            next_pin_oe[c]  = 1'b1;
          end
          2'b01:
          begin
            next_pin_out[c] = 1'b1;
            next_pin_oe[c]  = totem_pole_drive_select;
          end
          default:
          begin
            next_pin_out[c] = 1'b1;
            next_pin_oe[c]  = 1'b0;
          end
        endcase
      end
      else
      begin
        next_pin_out[c] = !low;
        next_pin_oe[c]  = low || totem_pole_drive_select;
      end
    end
  end
  // pins hold while asleep; no step of any pwm can reach them
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      led_pin_out <= {CHANNELS{1'b1}};
      led_pin_oe  <= {CHANNELS{1'b1}};
    end
    else if (!sleep)
    begin
      led_pin_out <= next_pin_out;
      led_pin_oe  <= next_pin_oe;
    end
  end
  wire unused_ok = blink_wrap & blink_step;
endmodule // led_output_pwm_stage
`default_nettype wire

/* logic/led_stage_consts.vh */
`ifndef LED_STAGE_CONSTS_VH
`define LED_STAGE_CONSTS_VH
// ==========================================================
// register map (byte addresses, one word each)
`define REG_MODE1        8'h00
`define REG_SECOND_MODE_REGISTER        8'h04
`define REG_GROUP_DUTY   8'h08
`define REG_GROUP_PERIOD 8'h0c
`define REG_SELECT       8'h10
`define REG_DUTY_BASE    8'h20
// ==========================================================
// field positions
`define MODE1_SLEEP_BIT  4
`define SECOND_MODE_REGISTER_BLINK_BIT  5
`define SECOND_MODE_REGISTER_INVERT_BIT 4
`define SECOND_MODE_REGISTER_TOTEM_BIT  2
`define SECOND_MODE_REGISTER_DISABLED_OUTPUT_STATE_LSB  0
// ==========================================================
// reset values
`define MODE1_RESET      8'h00
`define SECOND_MODE_REGISTER_RESET      8'h04
`define GROUP_DUTY_RESET 8'hff
// ==========================================================
// timing
`define CLK_HZ           25000000
`define IND_PWM_HZ       97000
`define GRP_DIM_HZ       190
`define BLINK_MAX_HZ     24
`define IND_TICK_CYCLES  (`CLK_HZ / (`IND_PWM_HZ * 256))
`define GRP_TICK_CYCLES  (`CLK_HZ / (`GRP_DIM_HZ * 256))
`define BLINK_TICK_CYCLES (`CLK_HZ / (`BLINK_MAX_HZ * 256))
`endif

/* logic/pwm_counter.v */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// free-running 8-bit pwm: prescaler then step counter
module pwm_counter
#(
  parameter PRESCALE = 1
)
(
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire [7:0] steps_m1,
  output reg  [7:0] phase,
  output wire       wrap
);
  reg  [23:0] pre;
  wire        tick;
  assign tick = (pre == PRESCALE[23:0] - 24'h000001);
  assign wrap = tick && (phase == 8'hff);
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pre   <= 24'h000000;
      phase <= 8'h00;
    end
    else if (run)
    begin
      pre <= tick ? 24'h000000 : pre + 24'h000001;
      if (tick)
        phase <= phase + 8'h01;
    end
  end
  // steps_m1 reserved for stretched periods handled by caller
  wire unused_ok;
  assign unused_ok = &steps_m1;
endmodule // pwm_counter
`default_nettype wire

/* verification/led_load.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================
// led loads with a pull-up: a released pin reads high
module led_load
(
  input  wire logic [7:0] led_pin_out,
  input  wire logic [7:0] led_pin_oe,
  output logic      [7:0] lvl
);
  assign lvl = led_pin_out | ~led_pin_oe;
endmodule // led_load
`default_nettype wire

/* verification/led_stage_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "led_stage_consts.vh"
// ====================
// port checker with shadow copies of the mode bits
module led_stage_chk
#(
  parameter CHANNELS = 8
)
(
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                output_disable,
  input wire logic [CHANNELS-1:0] led_pin_out,
  input wire logic [CHANNELS-1:0] led_pin_oe
);
  logic [7:0] m2;
  logic       slp;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      m2  <= `SECOND_MODE_REGISTER_RESET;
      slp <= 1'b0;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == `REG_SECOND_MODE_REGISTER) m2 <= pwdata[7:0];
      if (paddr == `REG_MODE1) slp <= pwdata[`MODE1_SLEEP_BIT];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // pin path is two sync flops plus the pin register
  sequence dis4;
    output_disable[*4];
  endsequence
  rdy_a: assert property (pready) else $error("pready low");
  rst_pins_a: assert property ($rose(rst_n) |-> (&led_pin_out && &led_pin_oe)[*3])
    else $error("pins not high after reset");
  bad_addr_a: assert property (psel && penable && paddr == 8'h14 |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (psel && penable && paddr == `REG_SECOND_MODE_REGISTER |-> !pslverr)
    else $error("mapped access refused");
  dis_low_a: assert property (dis4 ##0 m2[1:0] == 2'b00 |-> &led_pin_oe && !(|led_pin_out))
    else $error("disabled low wrong");
  dis_high_a: assert property (dis4 ##0 m2[1:0] == 2'b01 |->
    &led_pin_out && led_pin_oe == {CHANNELS{m2[`SECOND_MODE_REGISTER_TOTEM_BIT]}}) else $error("disabled high");
  dis_z_a: assert property (dis4 ##0 m2[1] |-> led_pin_oe == 0)
    else $error("disabled z wrong");
  sleep_a: assert property (slp[*6] |-> $stable(led_pin_out) && $stable(led_pin_oe))
    else $error("pins moved in sleep");
endmodule // led_stage_chk
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "led_stage_consts.vh"
// ====================
// apb driven bench, pwm measured by counting low cycles
module tb_top;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, output_disable = 0, err, lo;
  logic [7:0]  paddr = 0, led_pin_out, led_pin_oe, lvl;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr;
  int          n_errors = 0, samples_checked = 0, cyc = 0, k, ch;
  logic [31:0] cnt [8]; // four-state so an unknown pin level cannot hide in a count
  initial forever #20 ref_clk = ~ref_clk;
  led_output_pwm_stage #(.CHANNELS(8), .IND_CYCLES(1), .GRP_CYCLES(2), .BLINK_CYCLES(2)) dut
    (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
     .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
     .output_disable(output_disable), .led_pin_out(led_pin_out), .led_pin_oe(led_pin_oe));
  led_load ld (.led_pin_out(led_pin_out), .led_pin_oe(led_pin_oe), .lvl(lvl));
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a stuck wait ends here instead of hanging the run
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task measure(input int len);
    for (ch = 0; ch < 8; ch++) cnt[ch] = 0;
    repeat (len)
    begin
      @(negedge ref_clk);
      for (ch = 0; ch < 8; ch++) cnt[ch] += !lvl[ch];
    end
  endtask
  initial
  begin
    wt(4);
    rst_n <= 1;
    wt(1);
    @(negedge ref_clk);
    chk({led_pin_out, led_pin_oe}, 16'hffff);
    acc(0, `REG_SECOND_MODE_REGISTER, 0);
    chk(rd[7:0], `SECOND_MODE_REGISTER_RESET);
    acc(0, `REG_GROUP_DUTY, 0);
    chk(rd[7:0], `GROUP_DUTY_RESET);
    acc(0, 8'h14, 0);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    for (k = 0; k < 8; k++)
    begin
      acc(1, `REG_SECOND_MODE_REGISTER, (k[0] << 4) | (k[1] << 2));
      acc(1, `REG_SELECT, k[2] ? 32'h5555 : 32'h0);
      wt(8);
      lo = k[2] ^ k[0];
      @(negedge ref_clk);
      chk({led_pin_out, led_pin_oe}, {{8{!lo}}, {8{lo | k[1]}}});
    end
    for (ch = 0; ch < 8; ch++) acc(1, `REG_DUTY_BASE + 4 * ch, 32 * ch);
    acc(0, `REG_DUTY_BASE + 8'h1c, 0);
    chk(rd, 32'h000000e0);
    acc(1, `REG_SELECT, 32'haaaa);
    for (k = 0; k < 2; k++)
    begin
      acc(1, `REG_SECOND_MODE_REGISTER, k << 4);
      wt(8);
      measure(1024);
      for (ch = 0; ch < 8; ch++) chk(cnt[ch], k ? 1024 - 128 * ch : 128 * ch);
    end
    acc(1, `REG_SECOND_MODE_REGISTER, 0);
    acc(1, `REG_SELECT, 32'hffff);
    acc(1, `REG_GROUP_DUTY, 8'h80);
    wt(16);
    measure(1024);
    for (ch = 0; ch < 8; ch++) chk(cnt[ch], 64 * ch);
    acc(1, `REG_SECOND_MODE_REGISTER, 32'h20);
    acc(1, `REG_GROUP_PERIOD, 3);
    acc(1, `REG_GROUP_DUTY, 8'h40);
    wt(16);
    measure(2048);
    for (ch = 0; ch < 8; ch++) chk(cnt[ch], 64 * ch);
    for (k = 0; k < 3; k++)
    begin
      acc(1, `REG_SECOND_MODE_REGISTER, 32'h04 | k);
      wt(8);
      output_disable <= 1;
      wt(6);
      @(negedge ref_clk);
      chk({led_pin_oe, led_pin_out & led_pin_oe}, {k == 2 ? 8'h0 : 8'hff, k == 1 ? 8'hff : 8'h0});
      @(posedge ref_clk);
      output_disable <= 0;
      wt(6);
    end
    acc(1, `REG_MODE1, 32'h10);
    wt(8);
    measure(512);
    for (ch = 0; ch < 8; ch++) chk(cnt[ch] % 512, 0);
    acc(1, `REG_MODE1, 0);
    acc(1, `REG_SELECT, 32'haaaa);
    wt(8);
    measure(1024);
    for (ch = 0; ch < 8; ch++) chk(cnt[ch], 128 * ch);
    end_of_test;
  end
endmodule // tb_top
bind led_output_pwm_stage led_stage_chk #(.CHANNELS(CHANNELS)) chk_i
  (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .output_disable(output_disable), .led_pin_out(led_pin_out), .led_pin_oe(led_pin_oe));
`default_nettype wire
